// ==== src/banked_data_memory_file.sv ====
// data memory file: core registers, banked peripheral window, banked byte ram
// assumes one command per clock from the core; reads answer on the next edge
`timescale 1ns/1ps
// Function
// - memory splits into a general purpose ram area and a special function area of control and status.
// - the general purpose area is banked so more than 230 bytes can be reached.
// - bank bits come from the bank select register and do nothing for unbanked addresses.
// - the two move instructions copy a byte between peripheral window 00-1f and file 00-ff.
// - the peripheral window holds six spare locations that act as plain storage.
// - those spare locations sit at 1a to 1f for context saving.
// - all memory is reached directly or through two pointers, with bank bits applied.
// - each general purpose location holds one byte.
// - general purpose contents have no power-on value and survive other resets.
// - a literal instruction loads the ram bank selection.
// - a peripheral to file move leaves status bits and working register alone.
// - pointer zero increments after indirect use when low mode is set and high clear.
// - pointer zero decrements after indirect use when both mode bits are clear.
// - the first interrupt enable register is at 17h bank 1, read/write, zero after reset.
// - enable bits run port change, timer3, timer2, timer1, capture2, capture1, tx, rx.
// - peripheral registers are banked, core registers unbanked, with a periph bank literal.
module banked_data_memory_file
  import dmem_pkg::*;
#(
  parameter int unsigned NUM_RAM_BANKS = DEFAULT_RAM_BANKS
) (
  input  wire logic                I_CLK_SYS,
  input  wire logic                I_RST,
  input  op_t                      I_OP,
  input  wire logic [7:0]          I_F_ADDR,
  input  wire logic [4:0]          I_P_ADDR,
  input  wire logic [DATA_W-1:0]   I_WDATA,
  input  wire logic [3:0]          I_LITERAL,
  input  wire logic [7:0]          I_PERIPH_REQ,
  output logic      [DATA_W-1:0]   O_RDATA,
  output logic                     O_DONE,
  output logic                     O_PERIPH_IRQ
);
  localparam int unsigned DEPTH = NUM_RAM_BANKS * RAM_BANK_BYTES + SPARE_BYTES;
  localparam int unsigned IDX_W = $clog2(DEPTH);

  typedef struct packed {
    logic [7:0]        bank_sel;
    logic [7:0]        ptr_zero;
    logic [7:0]        ptr_one;
    logic [7:0]        arith_status;
    logic [7:0]        working;
    logic [7:0]        pie_first;
    logic [DATA_W-1:0] rdata;
    logic              done;
    logic              irq;
  } state_t;

  localparam state_t RESET_ST = '{
    bank_sel:     BANK_SELECT_RST,
    ptr_zero:     POINTER_RST,
    ptr_one:      POINTER_RST,
    arith_status: ARITH_STATUS_RST,
    working:      WORKING_RST,
    pie_first:    PIE_FIRST_RST,
    rdata:        8'h00,
    done:         1'b0,
    irq:          1'b0
  };

  state_t            st_q;
  state_t            st_d;
  logic [7:0]        src;
  logic [7:0]        dst;
  logic [7:0]        src_eff;
  logic [7:0]        dst_eff;
  logic              use_src;
  logic              use_dst;
  logic              touch_zero;
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] wr_val;
  logic [IDX_W-1:0]  ram_ridx;
  logic [IDX_W-1:0]  ram_widx;
  logic [DATA_W-1:0] ram_rdata;
  logic              ram_we;
  logic [3:0]        ram_bank;
  logic [3:0]        periph_bank;

  // the data slots resolve to the pointer value; pointing at them reads zero
  function automatic logic [7:0] resolve(input logic [7:0] a, input logic [7:0] p0,
                                         input logic [7:0] p1);
    if (a == ADDR_INDIRECT_DATA_ZERO) begin
      return p0;
    end else if (a == ADDR_INDIRECT_DATA_ONE) begin
      return p1;
    end else begin
      return a;
    end
  endfunction

  function automatic logic is_ram(input logic [7:0] a);
    return (a >= ADDR_RAM_BASE) || ((a >= ADDR_SPARE_LO) && (a <= ADDR_SPARE_HI));
  endfunction

  // spare slots sit after all banks, so bank bits never reach them
  function automatic logic [IDX_W-1:0] ram_index(input logic [7:0] a, input logic [3:0] bank);
    int unsigned b;
    b = int'(bank) % NUM_RAM_BANKS;
    if (a >= ADDR_RAM_BASE) begin
      return IDX_W'(b * RAM_BANK_BYTES + int'(a - ADDR_RAM_BASE));
    end else begin
      return IDX_W'(NUM_RAM_BANKS * RAM_BANK_BYTES + int'(a - ADDR_SPARE_LO));
    end
  endfunction

  assign ram_bank    = st_q.bank_sel[RAM_BANK_LSB +: 4];
  assign periph_bank = st_q.bank_sel[PERIPH_BANK_LSB +: 4];

  always_comb begin
    st_d     = st_q;
    st_d.done = 1'b0;
    st_d.irq = |(I_PERIPH_REQ & st_q.pie_first);
    src      = 8'h00;
    dst      = 8'h00;
    use_src  = 1'b0;
    use_dst  = 1'b0;
    case (I_OP)
      OP_READ: begin
        src     = I_F_ADDR;
        use_src = 1'b1;
        st_d.done = 1'b1;
      end
      OP_WRITE: begin
        dst     = I_F_ADDR;
        use_dst = 1'b1;
        st_d.done = 1'b1;
      end
      OP_MOVE_PERIPH_TO_FILE: begin
        src     = {3'h0, I_P_ADDR};
        dst     = I_F_ADDR;
        use_src = 1'b1;
        use_dst = 1'b1;
        st_d.done = 1'b1;
      end
      OP_MOVE_FILE_TO_PERIPH: begin
        src     = I_F_ADDR;
        dst     = {3'h0, I_P_ADDR};
        use_src = 1'b1;
        use_dst = 1'b1;
        st_d.done = 1'b1;
      end
      OP_LOAD_RAM_BANK: begin
        st_d.bank_sel[RAM_BANK_LSB +: 4] = I_LITERAL;
        st_d.done = 1'b1;
      end
      OP_LOAD_PERIPH_BANK: begin
        st_d.bank_sel[PERIPH_BANK_LSB +: 4] = I_LITERAL;
        st_d.done = 1'b1;
      end
      default: begin
      end
    endcase

    src_eff  = resolve(src, st_q.ptr_zero, st_q.ptr_one);
    dst_eff  = resolve(dst, st_q.ptr_zero, st_q.ptr_one);
    ram_ridx = ram_index(src_eff, ram_bank);
    ram_widx = ram_index(dst_eff, ram_bank);

    // read side; unimplemented peripheral slots read zero
    if (src_eff == ADDR_INDIRECT_POINTER_ZERO) begin
      rd_val = st_q.ptr_zero;
    end else if (src_eff == ADDR_INDIRECT_POINTER_ONE) begin
      rd_val = st_q.ptr_one;
    end else if (src_eff == ADDR_ARITH_STATUS) begin
      rd_val = st_q.arith_status;
    end else if (src_eff == ADDR_WORKING) begin
      rd_val = st_q.working;
    end else if (src_eff == ADDR_BANK_SELECT) begin
      rd_val = st_q.bank_sel;
    end else if ((src_eff == ADDR_PIE_FIRST) && (periph_bank == PIE_FIRST_BANK)) begin
      rd_val = st_q.pie_first;
    end else if (is_ram(src_eff)) begin
      rd_val = ram_rdata;
    end else begin
      rd_val = 8'h00;
    end
    if (use_src) begin
      st_d.rdata = rd_val;
    end
    wr_val = use_src ? rd_val : I_WDATA;

    // one auto step per command even if both operands use the data slot
    touch_zero = (use_src && (src == ADDR_INDIRECT_DATA_ZERO)) ||
                 (use_dst && (dst == ADDR_INDIRECT_DATA_ZERO));
    if (touch_zero && !st_q.arith_status[POINTER_MODE_HIGH_BIT]) begin
      if (st_q.arith_status[POINTER_MODE_LOW_BIT]) begin
        st_d.ptr_zero = st_q.ptr_zero + 8'h01;
      end else begin
        st_d.ptr_zero = st_q.ptr_zero - 8'h01;
      end
    end

    // write side; an explicit pointer write overrides the auto step
    ram_we = 1'b0;
    if (use_dst) begin
      if (dst_eff == ADDR_INDIRECT_POINTER_ZERO) begin
        st_d.ptr_zero = wr_val;
      end else if (dst_eff == ADDR_INDIRECT_POINTER_ONE) begin
        st_d.ptr_one = wr_val;
      end else if (dst_eff == ADDR_ARITH_STATUS) begin
        st_d.arith_status = wr_val;
      end else if (dst_eff == ADDR_WORKING) begin
        st_d.working = wr_val;
      end else if (dst_eff == ADDR_BANK_SELECT) begin
        st_d.bank_sel = wr_val;
      end else if ((dst_eff == ADDR_PIE_FIRST) && (periph_bank == PIE_FIRST_BANK)) begin
        st_d.pie_first = wr_val;
      end else if (is_ram(dst_eff)) begin
        ram_we = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      st_q <= RESET_ST;
    end else begin
      st_q <= st_d;
    end
  end

  gram_store #(
    .DEPTH (DEPTH),
    .IDX_W (IDX_W)
  ) u_store (
    .i_clk     (I_CLK_SYS),
    .i_rd_idx  (ram_ridx),
    .o_rd_data (ram_rdata),
    .i_wr_en   (ram_we),
    .i_wr_idx  (ram_widx),
    .i_wr_data (wr_val)
  );

  assign O_RDATA      = st_q.rdata;
  assign O_DONE       = st_q.done;
  assign O_PERIPH_IRQ = st_q.irq;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  sequence s_wr_spare;
    I_OP == OP_WRITE && I_F_ADDR == ADDR_SPARE_LO;
  endsequence
  sequence s_rd_spare;
    I_OP == OP_READ && I_F_ADDR == ADDR_SPARE_LO;
  endsequence
  sequence s_wr_ram;
    I_OP == OP_WRITE && I_F_ADDR == ADDR_RAM_BASE;
  endsequence
  sequence s_rd_ram;
    I_OP == OP_READ && I_F_ADDR == ADDR_RAM_BASE;
  endsequence
  property p_pie_reset;
    @(posedge I_CLK_SYS) disable iff (1'b0) I_RST |=> st_q.pie_first == PIE_FIRST_RST;
  endproperty
  a_pie_reset: assert property (p_pie_reset) else $error("enable register not zero after reset");

  property p_irq_mask;
    1'b1 |=> O_PERIPH_IRQ == $past(|(I_PERIPH_REQ & st_q.pie_first));
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt not gated by enables");

  property p_ram_bank;
    I_OP == OP_LOAD_RAM_BANK |=> ram_bank == $past(I_LITERAL);
  endproperty
  a_ram_bank: assert property (p_ram_bank) else $error("ram bank literal not loaded");

  property p_move_keeps_status;
    (I_OP == OP_MOVE_PERIPH_TO_FILE) && (dst_eff != ADDR_ARITH_STATUS) &&
      (dst_eff != ADDR_WORKING) |=> $stable(st_q.arith_status) && $stable(st_q.working);
  endproperty
  a_move_keeps_status: assert property (p_move_keeps_status) else $error("move touched status");

  property p_post_inc;
    (I_OP == OP_READ) && (I_F_ADDR == ADDR_INDIRECT_DATA_ZERO) &&
      st_q.arith_status[POINTER_MODE_LOW_BIT] && !st_q.arith_status[POINTER_MODE_HIGH_BIT]
      |=> st_q.ptr_zero == 8'($past(st_q.ptr_zero) + 8'h01);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("pointer zero did not increment");

  property p_post_dec;
    (I_OP == OP_READ) && (I_F_ADDR == ADDR_INDIRECT_DATA_ZERO) &&
      !st_q.arith_status[POINTER_MODE_LOW_BIT] && !st_q.arith_status[POINTER_MODE_HIGH_BIT]
      |=> st_q.ptr_zero == 8'($past(st_q.ptr_zero) - 8'h01);
  endproperty
  a_post_dec: assert property (p_post_dec) else $error("pointer zero did not decrement");

  property p_done;
    (I_OP == OP_MOVE_PERIPH_TO_FILE) || (I_OP == OP_MOVE_FILE_TO_PERIPH) |=>
      O_DONE ##1 (O_DONE == ($past(I_OP) != OP_NONE));
  endproperty
  a_done: assert property (p_done) else $error("move did not complete in one cycle");

  property p_spare_holds;
    s_wr_spare ##1 s_rd_spare |=> O_RDATA == $past(I_WDATA, 2);
  endproperty
  a_spare_holds: assert property (p_spare_holds) else $error("spare slot lost its byte");

  property p_spare_unbanked;
    s_wr_spare ##1 (I_OP == OP_LOAD_RAM_BANK) ##1 s_rd_spare |=> O_RDATA == $past(I_WDATA, 3);
  endproperty
  a_spare_unbanked: assert property (p_spare_unbanked) else $error("bank bits hit spare slot");

  property p_ram_holds;
    s_wr_ram ##1 s_rd_ram |=> O_RDATA == $past(I_WDATA, 2);
  endproperty
  a_ram_holds: assert property (p_ram_holds) else $error("banked ram lost its byte");
endmodule

// ==== src/dmem_pkg.sv ====
// constants, field layout and command codes for the banked data memory file
// assumes a single core clock and a core that issues one command per cycle
package dmem_pkg;
  localparam int unsigned DATA_W            = 8;
  localparam int unsigned RAM_BANK_BYTES    = 224;
  localparam int unsigned SPARE_BYTES       = 6;
  localparam int unsigned DEFAULT_RAM_BANKS = 4;

  // unbanked core registers
  localparam logic [7:0] ADDR_INDIRECT_DATA_ZERO    = 8'h00;
  localparam logic [7:0] ADDR_INDIRECT_POINTER_ZERO = 8'h01;
  localparam logic [7:0] ADDR_ARITH_STATUS          = 8'h04;
  localparam logic [7:0] ADDR_INDIRECT_DATA_ONE     = 8'h08;
  localparam logic [7:0] ADDR_INDIRECT_POINTER_ONE  = 8'h09;
  localparam logic [7:0] ADDR_WORKING               = 8'h0a;
  localparam logic [7:0] ADDR_BANK_SELECT           = 8'h0f;
  // banked peripheral window and general purpose areas
  localparam logic [7:0] ADDR_PIE_FIRST             = 8'h17;
  localparam logic [3:0] PIE_FIRST_BANK             = 4'h1;
  localparam logic [7:0] ADDR_SPARE_LO              = 8'h1a;
  localparam logic [7:0] ADDR_SPARE_HI              = 8'h1f;
  localparam logic [7:0] ADDR_RAM_BASE              = 8'h20;

  // field positions
  localparam int unsigned POINTER_MODE_LOW_BIT  = 2;
  localparam int unsigned POINTER_MODE_HIGH_BIT = 3;
  localparam int unsigned PERIPH_BANK_LSB       = 0;
  localparam int unsigned RAM_BANK_LSB          = 4;
  localparam int unsigned PORT_CHANGE_IRQ_EN    = 7;
  localparam int unsigned TIMER_THREE_IRQ_EN    = 6;
  localparam int unsigned TIMER_TWO_IRQ_EN      = 5;
  localparam int unsigned TIMER_ONE_IRQ_EN      = 4;
  localparam int unsigned CAPTURE_TWO_IRQ_EN    = 3;
  localparam int unsigned CAPTURE_ONE_IRQ_EN    = 2;
  localparam int unsigned SERIAL_ONE_TX_EMPTY_IRQ_EN = 1;
  localparam int unsigned SERIAL_ONE_RX_FULL_IRQ_EN  = 0;

  // values after reset
  localparam logic [7:0] PIE_FIRST_RST    = 8'h00;
  localparam logic [7:0] BANK_SELECT_RST  = 8'h00;
  localparam logic [7:0] ARITH_STATUS_RST = 8'h00;
  localparam logic [7:0] POINTER_RST      = 8'h00;
  localparam logic [7:0] WORKING_RST      = 8'h00;

  typedef enum logic [6:0] {
    OP_NONE                 = 7'h01,
    OP_READ                 = 7'h02,
    OP_WRITE                = 7'h04,
    OP_MOVE_PERIPH_TO_FILE  = 7'h08,
    OP_MOVE_FILE_TO_PERIPH  = 7'h10,
    OP_LOAD_RAM_BANK        = 7'h20,
    OP_LOAD_PERIPH_BANK     = 7'h40
  } op_t;
endpackage

// ==== src/gram_store.sv ====
// general purpose byte storage, one combinational read and one write port
// assumes the caller hands in a valid index; contents carry no reset at all
`timescale 1ns/1ps
module gram_store
  import dmem_pkg::*;
#(
  parameter int unsigned DEPTH = DEFAULT_RAM_BANKS * RAM_BANK_BYTES + SPARE_BYTES,
  parameter int unsigned IDX_W = $clog2(DEPTH)
) (
  input  wire logic                i_clk,
  input  wire logic [IDX_W-1:0]    i_rd_idx,
  output logic      [DATA_W-1:0]   o_rd_data,
  input  wire logic                i_wr_en,
  input  wire logic [IDX_W-1:0]    i_wr_idx,
  input  wire logic [DATA_W-1:0]   i_wr_data
);
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
  } store_t;

  store_t st_q;
  store_t st_d;

  always_comb begin
    st_d = st_q;
    if (i_wr_en) begin
      st_d.mem[i_wr_idx] = i_wr_data;
    end
  end

  // no reset term: power-on leaves it unknown, other resets keep it
  always_ff @(posedge i_clk) begin
    st_q <= st_d;
  end

  assign o_rd_data = st_q.mem[i_rd_idx];
endmodule

// ==== test/core_model.sv ====
// processor core model: drives one command per call into the data memory file
// assumes its tasks are entered 1 ns after a rising edge of i_clk
`timescale 1ns/1ps
module core_model
  import dmem_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_done,
  output op_t             o_op,
  output logic [7:0]      o_f_addr,
  output logic [4:0]      o_p_addr,
  output logic [7:0]      o_wdata,
  output logic [3:0]      o_literal,
  output logic [7:0]      o_periph_req
);
  initial begin
    o_op = OP_NONE;
    o_f_addr = 8'h00;
    o_p_addr = 5'h00;
    o_wdata = 8'h00;
    o_literal = 4'h0;
    o_periph_req = 8'h00;
  end

  // operands held until the edge that takes the command, answer read 1 ns later
  task automatic cmd(input op_t op, input logic [7:0] f, input logic [4:0] p,
                     input logic [7:0] wd, input logic [3:0] lit,
                     output logic [7:0] rd, output logic done);
    o_op = op;
    o_f_addr = f;
    o_p_addr = p;
    o_wdata = wd;
    o_literal = lit;
    @(posedge i_clk);
    #1;
    rd = i_rdata;
    done = i_done;
  endtask

  // idle operands flip so a stale value is never mistaken for a live one
  task automatic idle();
    o_op = OP_NONE;
    o_f_addr = ~o_f_addr;
    o_p_addr = ~o_p_addr;
    o_wdata = ~o_wdata;
    o_literal = ~o_literal;
    @(posedge i_clk);
    #1;
  endtask

  task automatic set_req(input logic [7:0] v);
    o_periph_req = v;
  endtask
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the banked data memory file
// assumes core_model drives every command input of the design
`timescale 1ns/1ps
module testbench;
  import dmem_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  op_t        op;
  logic [7:0] f_addr, wdata, preq, rdata, last_rd;
  logic [4:0] p_addr;
  logic [3:0] lit;
  logic       done, irq;
  int         errors = 0;
  int         comparisons = 0;

  always #50 clk = ~clk;

  banked_data_memory_file #(.NUM_RAM_BANKS(4)) uut (
    .I_CLK_SYS(clk), .I_RST(rst), .I_OP(op), .I_F_ADDR(f_addr), .I_P_ADDR(p_addr),
    .I_WDATA(wdata), .I_LITERAL(lit), .I_PERIPH_REQ(preq), .O_RDATA(rdata),
    .O_DONE(done), .O_PERIPH_IRQ(irq));

  core_model core (
    .i_clk(clk), .i_rdata(rdata), .i_done(done), .o_op(op), .o_f_addr(f_addr),
    .o_p_addr(p_addr), .o_wdata(wdata), .o_literal(lit), .o_periph_req(preq));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_op(input op_t o, input logic [7:0] f, input logic [4:0] p,
                       input logic [7:0] wd, input logic [3:0] l);
    logic d;
    core.cmd(o, f, p, wd, l, last_rd, d);
    chk({7'h00, d}, 8'h01);
  endtask

  task automatic wr(input logic [7:0] f, input logic [7:0] d);
    do_op(OP_WRITE, f, 5'h00, d, 4'h0);
  endtask

  task automatic rdc(input logic [7:0] f, input logic [7:0] exp);
    do_op(OP_READ, f, 5'h00, 8'h00, 4'h0);
    chk(last_rd, exp);
  endtask

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // tests run about 120 cycles, so 5000 cycles means a hang
  initial begin
    #(5000 * 100);
    errors++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    core.idle();
    chk({7'h00, done}, 8'h00);
    rdc(ADDR_BANK_SELECT, 8'h00);
    rdc(ADDR_WORKING, 8'h00);
    do_op(OP_LOAD_PERIPH_BANK, 8'h00, 5'h00, 8'h00, PIE_FIRST_BANK);
    rdc(ADDR_PIE_FIRST, PIE_FIRST_RST);
    wr(ADDR_PIE_FIRST, 8'ha5);
    rdc(ADDR_PIE_FIRST, 8'ha5);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_PIE_FIRST, 8'h01 << i);
      core.set_req(~(8'h01 << i));
      core.idle();
      chk({7'h00, irq}, 8'h00);
      core.set_req(8'h01 << i);
      core.idle();
      chk({7'h00, irq}, 8'h01);
    end
    wr(ADDR_PIE_FIRST, 8'h00);
    core.idle();
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_PIE_FIRST, 8'h80);
    core.idle();
    chk({7'h00, irq}, 8'h01);
    do_op(OP_LOAD_PERIPH_BANK, 8'h00, 5'h00, 8'h00, 4'h0);
    rdc(ADDR_PIE_FIRST, 8'h00);
    do_op(OP_LOAD_RAM_BANK, 8'h00, 5'h00, 8'h00, 4'h0);
    wr(ADDR_RAM_BASE, 8'h11);
    do_op(OP_LOAD_RAM_BANK, 8'h00, 5'h00, 8'h00, 4'h1);
    rdc(ADDR_BANK_SELECT, 8'h10);
    wr(ADDR_RAM_BASE, 8'h22);
    rdc(ADDR_RAM_BASE, 8'h22);
    do_op(OP_LOAD_RAM_BANK, 8'h00, 5'h00, 8'h00, 4'h0);
    rdc(ADDR_RAM_BASE, 8'h11);
    wr(ADDR_SPARE_LO, 8'h3c);
    rdc(ADDR_SPARE_LO, 8'h3c);
    wr(ADDR_SPARE_LO, 8'hc3);
    do_op(OP_LOAD_RAM_BANK, 8'h00, 5'h00, 8'h00, 4'h3);
    rdc(ADDR_SPARE_LO, 8'hc3);
    for (logic [7:0] a = ADDR_SPARE_LO; a <= ADDR_SPARE_HI; a++) begin
      wr(a, a ^ 8'hd9);
    end
    do_op(OP_LOAD_PERIPH_BANK, 8'h00, 5'h00, 8'h00, 4'h3);
    do_op(OP_LOAD_RAM_BANK, 8'h00, 5'h00, 8'h00, 4'h2);
    for (logic [7:0] a = ADDR_SPARE_LO; a <= ADDR_SPARE_HI; a++) begin
      rdc(a, a ^ 8'hd9);
    end
    wr(ADDR_WORKING, 8'h77);
    wr(ADDR_ARITH_STATUS, 8'h0c);
    do_op(OP_MOVE_PERIPH_TO_FILE, 8'h30, 5'h1a, 8'h00, 4'h0);
    chk(last_rd, 8'h1a ^ 8'hd9);
    rdc(8'h30, 8'h1a ^ 8'hd9);
    rdc(ADDR_WORKING, 8'h77);
    rdc(ADDR_ARITH_STATUS, 8'h0c);
    wr(8'h31, 8'h5e);
    do_op(OP_MOVE_FILE_TO_PERIPH, 8'h31, 5'h1f, 8'h00, 4'h0);
    rdc(ADDR_SPARE_HI, 8'h5e);
    wr(ADDR_INDIRECT_POINTER_ZERO, 8'h40);
    wr(ADDR_ARITH_STATUS, 8'h04);
    wr(ADDR_INDIRECT_DATA_ZERO, 8'ha1);
    wr(ADDR_INDIRECT_DATA_ZERO, 8'ha2);
    rdc(ADDR_INDIRECT_POINTER_ZERO, 8'h42);
    rdc(ADDR_ARITH_STATUS, 8'h04);
    rdc(8'h40, 8'ha1);
    rdc(8'h41, 8'ha2);
    wr(ADDR_INDIRECT_POINTER_ZERO, 8'h40);
    rdc(ADDR_INDIRECT_DATA_ZERO, 8'ha1);
    rdc(ADDR_INDIRECT_POINTER_ZERO, 8'h41);
    wr(ADDR_ARITH_STATUS, 8'h00);
    wr(ADDR_INDIRECT_POINTER_ZERO, 8'h41);
    rdc(ADDR_INDIRECT_DATA_ZERO, 8'ha2);
    rdc(ADDR_INDIRECT_DATA_ZERO, 8'ha1);
    rdc(ADDR_INDIRECT_POINTER_ZERO, 8'h3f);
    do_op(OP_LOAD_RAM_BANK, 8'h00, 5'h00, 8'h00, 4'h0);
    wr(ADDR_INDIRECT_POINTER_ONE, ADDR_RAM_BASE);
    rdc(ADDR_INDIRECT_DATA_ONE, 8'h11);
    do_op(OP_LOAD_RAM_BANK, 8'h00, 5'h00, 8'h00, 4'h1);
    rdc(ADDR_INDIRECT_DATA_ONE, 8'h22);
    rst = 1'b1;
    core.idle();
    core.idle();
    rst = 1'b0;
    core.idle();
    chk({7'h00, irq}, 8'h00);
    rdc(ADDR_RAM_BASE, 8'h11);
    do_op(OP_LOAD_PERIPH_BANK, 8'h00, 5'h00, 8'h00, PIE_FIRST_BANK);
    rdc(ADDR_PIE_FIRST, PIE_FIRST_RST);
    core.idle();
    results();
  end
endmodule
